/* File: common/scc_pkg.sv */
// Constants, encodings and register map of the snoop and shareability control block.
// Assumes one clock domain and a single word-wide register port.
//
// Overview of operation
// - One snoop control register per slave port.
// - Bit 31 shows DVM support, read-only.
// - Bit 30 shows snoop support, ports 3-4 only.
// - Bit 1 DVM enable, resets zero.
// - Bit 0 snoop enable, resets zero.
// - Channel absent: all snoop register writes dropped.
// - Snoops globally off: snoop enable writes dropped.
// - DVM globally off: DVM enable writes dropped.
// - Non-secure access only when permitted.
// - Domain override only on ACE-Lite ports.
// - FIXED, device, barrier, DVM never overridden.
// - Two-bit override field, resets zero, 0-1 pass.
// - Mode 2 forces non-shareable, converts types.
// - Mode 3 forces shareable, converts types.
// - Forced shareable exclusives become normal accesses.
// - Converted exclusive write answers OKAY.
// - Bits 29 to 2 read zero.
package scc_pkg;

  // ---------------------------------------------------------------
  // Geometry and register map
  // ---------------------------------------------------------------
  localparam int SCC_NPORTS = 5;
  localparam int SCC_AW = 8;
  localparam int SCC_DW = 32;
  localparam int SCC_STRIDE = 4;
  localparam logic [SCC_AW-1:0] SCC_SNP_BASE = 8'h00;
  localparam logic [SCC_AW-1:0] SCC_OVR_BASE = 8'h20;
  localparam logic [SCC_NPORTS-1:0] SCC_SNP_CAPABLE = 5'h18;
  localparam logic [SCC_NPORTS-1:0] SCC_ACE_LITE = 5'h07;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SCC_DVM_SUP_BIT = 31;
  localparam int SCC_SNP_SUP_BIT = 30;
  localparam int SCC_RSV_MSB = 29;
  localparam int SCC_RSV_LSB = 2;
  localparam int SCC_DVM_EN_BIT = 1;
  localparam int SCC_SNP_EN_BIT = 0;
  localparam int SCC_OVR_LSB = 0;
  localparam int SCC_OVR_W = 2;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCC_OVR_PASS0 = 2'h0,
    SCC_OVR_PASS1 = 2'h1,
    SCC_OVR_NONSH = 2'h2,
    SCC_OVR_SHARE = 2'h3
  } scc_ovr_t;

  localparam logic [1:0] SCC_OVR_RST = 2'h0;
  localparam logic [1:0] SCC_DOM_NONSH = 2'h0;
  localparam logic [1:0] SCC_DOM_INNER = 2'h1;
  localparam logic [3:0] SCC_SNP_NOSNOOP = 4'h0;
  localparam logic [3:0] SCC_SNP_LINEUNIQ = 4'h1;
  localparam logic [1:0] SCC_BURST_FIXED = 2'h0;
  localparam logic [1:0] SCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCC_RESP_EXOKAY = 2'h1;

endpackage : scc_pkg

/* File: src/scc_dom_rewrite.sv */
// Domain and transaction type rewrite for one slave port request channel.
// Assumes the request and response beats come as one-cycle valid pulses.
`timescale 1ns/1ps
module scc_dom_rewrite
  import scc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] mode_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_domain_i,
  input wire logic [3:0] req_snoop_i,
  input wire logic [1:0] req_burst_i,
  input wire logic req_device_i,
  input wire logic req_barrier_i,
  input wire logic req_dvm_i,
  input wire logic req_excl_i,
  input wire logic rsp_valid_i,
  input wire logic [1:0] rsp_i,
  output logic out_valid_o,
  output logic [1:0] out_domain_o,
  output logic [3:0] out_snoop_o,
  output logic out_excl_o,
  output logic rsp_valid_o,
  output logic [1:0] rsp_o
);

  typedef struct packed {
    logic valid;
    logic [1:0] domain;
    logic [3:0] snoop;
    logic excl;
    logic rvalid;
    logic [1:0] resp;
  } scc_rw_t;

  scc_rw_t q, d;
  logic keep;

  // ---------------------------------------------------------------
  // Rewrite
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    keep = (req_burst_i == SCC_BURST_FIXED) | req_device_i | req_barrier_i | req_dvm_i;
    d.valid = req_valid_i;
    d.domain = req_domain_i;
    d.snoop = req_snoop_i;
    d.excl = req_excl_i;
    if (!keep && mode_i == SCC_OVR_NONSH) begin
      d.domain = SCC_DOM_NONSH;
      // ReadOnce and WriteUnique share code with their no-snoop forms
      if (req_write_i && req_snoop_i == SCC_SNP_LINEUNIQ) begin
        d.snoop = SCC_SNP_NOSNOOP;
      end
    end else if (!keep && mode_i == SCC_OVR_SHARE) begin
      d.domain = SCC_DOM_INNER;
      d.excl = 1'b0;
    end
    d.rvalid = rsp_valid_i;
    d.resp = rsp_i;
    // No exclusive monitor downstream once stripped, so never pass EXOKAY
    if (mode_i == SCC_OVR_SHARE && rsp_i == SCC_RESP_EXOKAY) begin
      d.resp = SCC_RESP_OKAY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_valid_o = q.valid;
  assign out_domain_o = q.domain;
  assign out_snoop_o = q.snoop;
  assign out_excl_o = q.excl;
  assign rsp_valid_o = q.rvalid;
  assign rsp_o = q.resp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  bypass_domain_a: assert property (req_valid_i && keep |=> out_domain_o == $past(req_domain_i))
    else $error("bypass request domain changed");
  // Only writes carry the line-unique code that must fold to no-snoop
  nonsh_force_a: assert property (req_valid_i && req_write_i && !keep && mode_i == SCC_OVR_NONSH
    |=> out_valid_o && out_domain_o == SCC_DOM_NONSH && out_snoop_o != SCC_SNP_LINEUNIQ)
    else $error("non-shareable override not applied");
  share_force_a: assert property (req_valid_i && !keep && mode_i == SCC_OVR_SHARE
    |=> out_domain_o == SCC_DOM_INNER && !out_excl_o)
    else $error("shareable override not applied");
  okay_resp_a: assert property (rsp_valid_i && mode_i == SCC_OVR_SHARE
    |=> rsp_valid_o && rsp_o != SCC_RESP_EXOKAY)
    else $error("exclusive okay leaked under shareable override");

endmodule : scc_dom_rewrite

/* File: src/scc_ctrl.sv */
// Snoop and DVM request control for all slave ports plus shareability override for the ACE-Lite ports.
// Assumes a single-cycle register port and request pulses in the same clock.
`timescale 1ns/1ps
module scc_ctrl
  import scc_pkg::*;
#(
  parameter int N_PORTS = SCC_NPORTS,
  parameter logic [N_PORTS-1:0] SNOOP_CAPABLE = SCC_SNP_CAPABLE,
  parameter logic [N_PORTS-1:0] ACE_LITE = SCC_ACE_LITE
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [SCC_AW-1:0] reg_addr_i,
  input wire logic [SCC_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_secure_i,
  output logic [SCC_DW-1:0] reg_rdata_o,
  // Global settings held elsewhere
  input wire logic nonsecure_allow_i,
  input wire logic snoop_off_i,
  input wire logic dvm_off_i,
  input wire logic [N_PORTS-1:0] snoop_channel_present_in_i,
  // Request gating
  input wire logic [N_PORTS-1:0] snoop_req_i,
  input wire logic [N_PORTS-1:0] dvm_req_i,
  output logic [N_PORTS-1:0] snoop_req_o,
  output logic [N_PORTS-1:0] dvm_req_o,
  // Incoming request channels
  input wire logic [N_PORTS-1:0] req_valid_i,
  input wire logic [N_PORTS-1:0] req_write_i,
  input wire logic [2*N_PORTS-1:0] req_domain_i,
  input wire logic [4*N_PORTS-1:0] req_snoop_i,
  input wire logic [2*N_PORTS-1:0] req_burst_i,
  input wire logic [N_PORTS-1:0] req_device_i,
  input wire logic [N_PORTS-1:0] req_barrier_i,
  input wire logic [N_PORTS-1:0] req_dvm_i,
  input wire logic [N_PORTS-1:0] req_excl_i,
  input wire logic [N_PORTS-1:0] rsp_valid_i,
  input wire logic [2*N_PORTS-1:0] rsp_i,
  output logic [N_PORTS-1:0] out_valid_o,
  output logic [2*N_PORTS-1:0] out_domain_o,
  output logic [4*N_PORTS-1:0] out_snoop_o,
  output logic [N_PORTS-1:0] out_excl_o,
  output logic [N_PORTS-1:0] rsp_valid_o,
  output logic [2*N_PORTS-1:0] rsp_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [N_PORTS-1:0] snp_en;
    logic [N_PORTS-1:0] dvm_en;
    logic [2*N_PORTS-1:0] ovr;
    logic [SCC_DW-1:0] rdata;
  } scc_regs_t;

  scc_regs_t q, d;
  logic acc_ok;
  logic [N_PORTS-1:0] snp_hit;
  logic [N_PORTS-1:0] ovr_hit;
  logic [N_PORTS-1:0] snp_sup;
  logic [N_PORTS-1:0] dvm_sup;
  logic [N_PORTS-1:0] snp_act;
  logic [N_PORTS-1:0] dvm_act;

  // ---------------------------------------------------------------
  // Support and effective enables
  // ---------------------------------------------------------------
  // Support bits read zero under the global override
  assign snp_sup = snoop_channel_present_in_i & SNOOP_CAPABLE & {N_PORTS{!snoop_off_i}};
  assign dvm_sup = snoop_channel_present_in_i & {N_PORTS{!dvm_off_i}};
  // Enable bit is masked so a dropped support also stops requests
  assign snp_act = q.snp_en & snp_sup;
  assign dvm_act = q.dvm_en & dvm_sup;
  assign snoop_req_o = snoop_req_i & snp_act;
  assign dvm_req_o = dvm_req_i & dvm_act;

  assign acc_ok = reg_secure_i | nonsecure_allow_i;

  // ---------------------------------------------------------------
  // Register decode, write and read
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.rdata = '0;
    for (int p = 0; p < N_PORTS; p++) begin
      snp_hit[p] = (reg_addr_i == SCC_AW'(SCC_SNP_BASE + p * SCC_STRIDE));
      ovr_hit[p] = (reg_addr_i == SCC_AW'(SCC_OVR_BASE + p * SCC_STRIDE));
    end
    for (int p = 0; p < N_PORTS; p++) begin
      if (reg_wr_i && acc_ok && snp_hit[p] && snoop_channel_present_in_i[p]) begin
        if (snp_sup[p]) begin
          d.snp_en[p] = reg_wdata_i[SCC_SNP_EN_BIT];
        end
        if (dvm_sup[p]) begin
          d.dvm_en[p] = reg_wdata_i[SCC_DVM_EN_BIT];
        end
      end else if (reg_wr_i && acc_ok && ovr_hit[p] && ACE_LITE[p]) begin
        d.ovr[2*p +: 2] = reg_wdata_i[SCC_OVR_LSB +: SCC_OVR_W];
      end
      if (reg_rd_i && acc_ok && snp_hit[p]) begin
        // Reserved field stays at the zero set above
        d.rdata[SCC_DVM_SUP_BIT] = dvm_sup[p];
        d.rdata[SCC_SNP_SUP_BIT] = snp_sup[p];
        d.rdata[SCC_DVM_EN_BIT] = dvm_act[p];
        d.rdata[SCC_SNP_EN_BIT] = snp_act[p];
      end else if (reg_rd_i && acc_ok && ovr_hit[p] && ACE_LITE[p]) begin
        d.rdata[SCC_OVR_LSB +: SCC_OVR_W] = q.ovr[2*p +: 2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      // Enables and override field all reset to zero
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;

  // ---------------------------------------------------------------
  // Per-port rewrite
  // ---------------------------------------------------------------
  for (genvar g = 0; g < N_PORTS; g++) begin : g_port
    logic [1:0] mode;
    // Fully coherent ports never see the override
    assign mode = ACE_LITE[g] ? q.ovr[2*g +: 2] : SCC_OVR_PASS0;

    scc_dom_rewrite u_rw (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .mode_i(mode),
      .req_valid_i(req_valid_i[g]),
      .req_write_i(req_write_i[g]),
      .req_domain_i(req_domain_i[2*g +: 2]),
      .req_snoop_i(req_snoop_i[4*g +: 4]),
      .req_burst_i(req_burst_i[2*g +: 2]),
      .req_device_i(req_device_i[g]),
      .req_barrier_i(req_barrier_i[g]),
      .req_dvm_i(req_dvm_i[g]),
      .req_excl_i(req_excl_i[g]),
      .rsp_valid_i(rsp_valid_i[g]),
      .rsp_i(rsp_i[2*g +: 2]),
      .out_valid_o(out_valid_o[g]),
      .out_domain_o(out_domain_o[2*g +: 2]),
      .out_snoop_o(out_snoop_o[4*g +: 4]),
      .out_excl_o(out_excl_o[g]),
      .rsp_valid_o(rsp_valid_o[g]),
      .rsp_o(rsp_o[2*g +: 2])
    );
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  localparam logic [SCC_AW-1:0] SNP3_ADDR = SCC_AW'(SCC_SNP_BASE + 3 * SCC_STRIDE);

  reset_clear_a: assert property (disable iff (1'b0) reset_i |=> q.snp_en == '0
    && q.dvm_en == '0 && q.ovr == '0)
    else $error("enables or override not cleared by reset");
  snp_wr_block_a: assert property (snoop_off_i |=> $stable(q.snp_en))
    else $error("snoop enable changed while snoops globally off");
  dvm_wr_block_a: assert property (dvm_off_i |=> $stable(q.dvm_en))
    else $error("DVM enable changed while DVM globally off");
  nonsec_block_a: assert property (reg_wr_i && !acc_ok
    |=> $stable({q.snp_en, q.dvm_en, q.ovr}))
    else $error("refused access changed a register");
  absent_req_a: assert property (((snoop_req_o | dvm_req_o)
    & ~snoop_channel_present_in_i) == '0)
    else $error("request issued to port without snoop channel");
  gate_req_a: assert property ((snoop_req_o & ~q.snp_en) == '0
    && (dvm_req_o & ~q.dvm_en) == '0)
    else $error("request passed a disabled port");
  support_read_a: assert property (reg_rd_i && reg_secure_i && reg_addr_i == SNP3_ADDR
    |=> reg_rdata_o[SCC_SNP_SUP_BIT] == $past(snp_sup[3])
    && reg_rdata_o[SCC_DVM_SUP_BIT] == $past(dvm_sup[3])
    && reg_rdata_o[SCC_RSV_MSB:SCC_RSV_LSB] == '0)
    else $error("snoop control readback wrong");
  port0_nosnp_a: assert property (reg_rd_i && reg_addr_i == SCC_SNP_BASE
    |=> !reg_rdata_o[SCC_SNP_SUP_BIT] || SNOOP_CAPABLE[0])
    else $error("snoop support shown on incapable port");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data outside the read answer cycle");

  snp_enable_c: cover property (reg_wr_i && reg_addr_i == SNP3_ADDR ##1 snp_act[3]);
  share_mode_c: cover property (q.ovr[1:0] == SCC_OVR_SHARE && req_valid_i[0]);
  nonsh_mode_c: cover property (q.ovr[1:0] == SCC_OVR_NONSH && req_valid_i[0]);
  snoop_pass_c: cover property (snoop_req_o[4] && dvm_req_o[4]);

endmodule : scc_ctrl

/* File: dv/scc_master_model.sv */
// Stand-in for the masters on the slave ports: request and response beats.
// Assumes the bench calls send through the instance, one beat at a time.
`timescale 1ns/1ps
module scc_master_model
  import scc_pkg::*;
(
  input wire logic clk_i,
  output logic [SCC_NPORTS-1:0] req_valid_o,
  output logic [SCC_NPORTS-1:0] req_write_o,
  output logic [2*SCC_NPORTS-1:0] req_domain_o,
  output logic [4*SCC_NPORTS-1:0] req_snoop_o,
  output logic [2*SCC_NPORTS-1:0] req_burst_o,
  output logic [SCC_NPORTS-1:0] req_device_o,
  output logic [SCC_NPORTS-1:0] req_barrier_o,
  output logic [SCC_NPORTS-1:0] req_dvm_o,
  output logic [SCC_NPORTS-1:0] req_excl_o,
  output logic [SCC_NPORTS-1:0] rsp_valid_o,
  output logic [2*SCC_NPORTS-1:0] rsp_o
);
  initial begin
    {req_valid_o, req_write_o, req_domain_o, req_snoop_o, req_burst_o} = '0;
    {req_device_o, req_barrier_o, req_dvm_o, req_excl_o, rsp_valid_o, rsp_o} = '0;
  end

  // Kind k: 0 normal, 1 fixed burst, 2 device, 3 barrier, 4 DVM message
  task automatic send(input int p, input logic w, input logic [1:0] dom,
                      input logic [3:0] snp, input int k, input logic ex);
    @(posedge clk_i);
    req_valid_o[p] <= 1'b1;
    req_write_o[p] <= w;
    req_domain_o[2*p+:2] <= dom;
    req_snoop_o[4*p+:4] <= snp;
    req_burst_o[2*p+:2] <= (k == 1) ? SCC_BURST_FIXED : 2'h1;
    req_device_o[p] <= (k == 2);
    req_barrier_o[p] <= (k == 3);
    req_dvm_o[p] <= (k == 4);
    req_excl_o[p] <= ex;
    rsp_valid_o[p] <= 1'b1;
    rsp_o[2*p+:2] <= ex ? SCC_RESP_EXOKAY : SCC_RESP_OKAY;
    @(posedge clk_i);
    req_valid_o <= '0;
    rsp_valid_o <= '0;
    req_excl_o <= '0;
    // Scrambled between beats so a stale qualifier cannot pass for a new one
    req_domain_o <= ~req_domain_o;
    req_snoop_o <= ~req_snoop_o;
    rsp_o <= ~rsp_o;
  endtask : send
endmodule : scc_master_model

/* File: dv/snoop_and_shareability_control_test.sv */
// Self-checking bench of the snoop and shareability control block.
// Assumes the scc_pkg register map and one 40 MHz clock.
`timescale 1ns/1ps
module snoop_and_shareability_control_test
  import scc_pkg::*;
;
  localparam int NP = SCC_NPORTS;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [SCC_AW-1:0] addr = '0;
  logic [SCC_DW-1:0] wdata = '0;
  logic wr = 1'b0, rd = 1'b0, sec = 1'b1, allow = 1'b0, soff = 1'b0, doff = 1'b0;
  logic [NP-1:0] present = '1, sreq = '1, dreq = '1;
  logic [SCC_DW-1:0] rdata;
  logic [NP-1:0] sreq_o, dreq_o, ov, oex, rv, mv, mw, mdev, mbar, mdvm, mex, mrv;
  logic [2*NP-1:0] od, ro, mdom, mbur, mrsp;
  logic [4*NP-1:0] os, msnp;
  logic [31:0] d;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;

  scc_ctrl dut (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_secure_i(sec), .reg_rdata_o(rdata),
    .nonsecure_allow_i(allow), .snoop_off_i(soff), .dvm_off_i(doff),
    .snoop_channel_present_in_i(present), .snoop_req_i(sreq), .dvm_req_i(dreq),
    .snoop_req_o(sreq_o), .dvm_req_o(dreq_o), .req_valid_i(mv), .req_write_i(mw),
    .req_domain_i(mdom), .req_snoop_i(msnp), .req_burst_i(mbur), .req_device_i(mdev),
    .req_barrier_i(mbar), .req_dvm_i(mdvm), .req_excl_i(mex), .rsp_valid_i(mrv),
    .rsp_i(mrsp), .out_valid_o(ov), .out_domain_o(od), .out_snoop_o(os),
    .out_excl_o(oex), .rsp_valid_o(rv), .rsp_o(ro));

  scc_master_model mdl (.clk_i(clk_i), .req_valid_o(mv), .req_write_o(mw),
    .req_domain_o(mdom), .req_snoop_o(msnp), .req_burst_o(mbur), .req_device_o(mdev),
    .req_barrier_o(mbar), .req_dvm_o(mdvm), .req_excl_o(mex), .rsp_valid_o(mrv),
    .rsp_o(mrsp));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Whole run is well under 1000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Access and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [SCC_AW-1:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rc(input string nm, input logic [SCC_AW-1:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
    chk(nm, d, exp);
  endtask : rc

  function automatic logic [SCC_AW-1:0] sa(input int p);
    return SCC_SNP_BASE + SCC_AW'(SCC_STRIDE * p);
  endfunction : sa

  function automatic logic [SCC_AW-1:0] oa(input int p);
    return SCC_OVR_BASE + SCC_AW'(SCC_STRIDE * p);
  endfunction : oa

  // Enables read back only where the port currently supports them
  function automatic logic [31:0] se(input int p, input logic [1:0] en);
    logic ds, ss;
    ds = present[p] & ~doff;
    ss = present[p] & SCC_SNP_CAPABLE[p] & ~soff;
    return {ds, ss, 28'h0, en[1] & ds, en[0] & ss};
  endfunction : se

  task automatic rw(input int p, input logic [1:0] m, input int k, input logic ex);
    logic [1:0] dom;
    logic [3:0] snp;
    logic exo;
    dom = (k != 0 || m < 2'h2) ? 2'h2 : {1'b0, m[0]};
    snp = (k == 0 && m == 2'h2) ? SCC_SNP_NOSNOOP : SCC_SNP_LINEUNIQ;
    exo = ex & (m != 2'h3);
    mdl.send(p, 1'b1, 2'h2, SCC_SNP_LINEUNIQ, k, ex);
    #1 chk("rewrite",
           {21'h0, ov[p], od[2*p+:2], os[4*p+:4], oex[p], rv[p], ro[2*p+:2]},
           {21'h0, 1'b1, dom, snp, exo, 1'b1, exo ? SCC_RESP_EXOKAY : SCC_RESP_OKAY});
  endtask : rw

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int p = 0; p < NP; p++) rc("snoop reset", sa(p), se(p, 2'h0));
    for (int p = 0; p < 3; p++) rc("override reset", oa(p), 32'h0);
    for (int p = 0; p < NP; p++) wr_reg(sa(p), 32'hFFFFFFFF);
    for (int p = 0; p < NP; p++) rc("snoop all", sa(p), se(p, 2'h3));
    @(posedge clk_i);
    sreq <= 5'h15;
    dreq <= 5'h0A;
    #1 chk("snoop gate", 32'(sreq_o), 32'(5'h15 & SCC_SNP_CAPABLE));
    chk("dvm gate", 32'(dreq_o), 32'h0A);
    for (int p = 0; p < NP; p++) wr_reg(sa(p), 32'h0);
    #1 chk("gate off", 32'({sreq_o, dreq_o}), 32'h0);
    // Snoops off, then DVM off, each with both enables written
    @(posedge clk_i);
    soff <= 1'b1;
    wr_reg(sa(3), 32'h3);
    rc("snoop off read", sa(3), se(3, 2'h2));
    soff <= 1'b0;
    doff <= 1'b1;
    wr_reg(sa(4), 32'h3);
    rc("dvm off read", sa(4), se(4, 2'h1));
    doff <= 1'b0;
    // Let the new setting land before the expected value is worked out
    #1;
    rc("snoop off kept", sa(3), se(3, 2'h2));
    rc("dvm off kept", sa(4), se(4, 2'h1));
    // Channel absent on port 3
    @(posedge clk_i);
    present <= 5'h17;
    wr_reg(sa(3), 32'h0);
    rc("absent read", sa(3), se(3, 2'h2));
    present <= 5'h1F;
    #1;
    rc("absent kept", sa(3), se(3, 2'h2));
    // Non-secure access, refused then permitted
    @(posedge clk_i);
    sec <= 1'b0;
    wr_reg(sa(3), 32'h1);
    rc("nonsecure read", sa(3), 32'h0);
    sec <= 1'b1;
    rc("nonsecure kept", sa(3), se(3, 2'h2));
    sec <= 1'b0;
    allow <= 1'b1;
    wr_reg(sa(3), 32'h1);
    rc("nonsecure allowed", sa(3), se(3, 2'h1));
    sec <= 1'b1;
    allow <= 1'b0;
    rc("unmapped", 8'h40, 32'h0);
    // Every override mode against every transaction kind
    for (int m = 0; m < 4; m++) begin
      wr_reg(oa(0), 32'(m));
      rc("override field", oa(0), 32'(m));
      for (int k = 0; k < 5; k++) rw(0, 2'(m), k, k == 0);
    end
    wr_reg(oa(3), 32'h3);
    rc("override absent", oa(3), 32'h0);
    rw(3, 2'h0, 0, 1'b0);
    report_and_stop();
  end
endmodule : snoop_and_shareability_control_test
